/* logic/dcb_pkg.sv */
// Shared constants and types of the directional overcurrent event block.
// Assumes a single 125 MHz clock; no bus, all settings arrive as ports.
`default_nettype none
package dcb_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int CYCLE_US = 5000;
	localparam int CYCLE_CLKS = CYCLE_US * CLK_MHZ;
	localparam int DIVW = 20;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NSTG = 4;
	localparam int NREC = 12;
	localparam int TW = 20;
	localparam int IW = 16;
	localparam int AW = 17;
	localparam int HW = 13;
	localparam int TSW = 48;
	localparam int NSIG = 6;
	localparam int NEV = 12;
	localparam int RATIO_SCALE = 100;

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	localparam logic [1:0] EVSEL_BOTH = 2'h0;
	localparam logic [1:0] EVSEL_ON = 2'h1;
	localparam logic [1:0] EVSEL_OFF = 2'h2;
	localparam logic [2:0] BEH_ON = 3'h1;
	localparam logic [2:0] BEH_BLK = 3'h2;
	localparam logic [2:0] BEH_TEST = 3'h3;
	localparam logic [2:0] BEH_TBLK = 3'h4;
	localparam logic [2:0] BEH_OFF = 3'h5;
	localparam logic [3:0] EV_START_ON = 4'h0;
	localparam logic [3:0] EV_TRIP_ON = 4'h2;
	localparam logic [3:0] EV_BLOCK_ON = 4'h4;
	localparam int SIG_NFILT = 3;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [3:0] PTR_RST = 4'h0;
	localparam logic [TW-1:0] TIME_RST = 20'h0;

	typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_TRIP, ST_REL, ST_BLK} dcb_state_e;
endpackage : dcb_pkg
`default_nettype wire

/* logic/dcb_dir_overcurrent_event_block.sv */
// Blocking, status, event and record logic of four directional overcurrent stages.
// Assumes pick-up, measurements, curve times and a ms time stamp come from same-clock logic;
// only the blocking inputs arrive from outside and are synchronised.
//
// Notes on behaviour
// - Blocking input sampled once at each cycle start, before pick-up and timing.
// - External block comes from a dedicated per-stage input fed by the routing matrix.
// - Inrush blocking option, off by default, blocks only the internal trip.
// - Inrush threshold is second-harmonic ratio in 0.01 percent steps.
// - Pick-up without block asserts start and begins operate timing.
// - Block present at pick-up asserts blocked, no timing or trip.
// - Block after start clears operate timer and runs release timing.
// - Entering blocked raises display note and event with currents and fault type.
// - Definite-time and inverse delays for both operate and reset.
// - Events on start, trip, blocked changes; setting picks on, off or both.
// - Four stages; each event tagged with its stage number.
// - Per stage events for start, trip, block, no-voltage, live angle, voltage memory.
// - Every event carries time stamp and process values.
// - Each stage keeps the twelve most recent records.
// - Record written only on on-edge of start, trip or blocked.
// - Record holds time, event, fault type, currents, remaining time, group, angle.
// - Live operating angle published in 0.01 degree units, signed.
// - Expected operating time in 5 ms steps, follows inverse curve time.
// - Remaining time to trip published as signed count-down while timing.
// - Ratio of highest phase current to pick-up setting published.
// - Behaviour state coded 1 on, 2 blocked, 3 test, 4 test-blocked, 5 off.
`timescale 1ns/10ps
`default_nettype none
module dcb_dir_overcurrent_event_block #(
	parameter int CYCLE_CLKS = dcb_pkg::CYCLE_CLKS // Clocks per 5 ms program cycle
) (
	input wire logic clk, // 125 MHz clock
	input wire logic rst, // Synchronous reset, high
	input wire logic [dcb_pkg::NSTG-1:0] pickup, // Pick-up element active
	input wire logic [dcb_pkg::NSTG-1:0] block_in, // Block from routing matrix
	input wire logic [dcb_pkg::NSTG-1:0] inrush_en, // Inrush blocking enable
	input wire logic [dcb_pkg::HW-1:0] harm_ratio, // 2nd/fund ratio, 0.01 %
	input wire logic [dcb_pkg::NSTG-1:0][dcb_pkg::HW-1:0] harm_limit, // Inrush limit
	input wire logic [dcb_pkg::NSTG-1:0] delay_inv, // 1 inverse, 0 definite time
	input wire logic [dcb_pkg::NSTG-1:0][dcb_pkg::TW-1:0] op_def, // Definite operate delay
	input wire logic [dcb_pkg::NSTG-1:0][dcb_pkg::TW-1:0] op_inv, // Inverse operate time
	input wire logic [dcb_pkg::NSTG-1:0][dcb_pkg::TW-1:0] rs_def, // Definite reset delay
	input wire logic [dcb_pkg::NSTG-1:0][dcb_pkg::TW-1:0] rs_inv, // Inverse reset time
	input wire logic [dcb_pkg::NSTG-1:0][2:0] set_mode, // Requested behaviour
	input wire logic [dcb_pkg::NSTG-1:0][1:0] ev_sel, // Event edge selection
	input wire logic [dcb_pkg::NSTG-1:0] no_volt, // No voltage, blocking
	input wire logic [dcb_pkg::NSTG-1:0] live_ang, // Live angle measured
	input wire logic [dcb_pkg::NSTG-1:0] volt_mem, // Voltage memory in use
	input wire logic [dcb_pkg::IW-1:0] i_max, // Highest phase current
	input wire logic [dcb_pkg::NSTG-1:0][dcb_pkg::IW-1:0] i_set, // Pick-up setting
	input wire logic [dcb_pkg::IW-1:0] i_pre, // Current 20 ms before
	input wire logic [dcb_pkg::IW-1:0] i_avg, // 200 ms pre-fault average
	input wire logic [3:0] fault_type, // Faulted loop code
	input wire logic [2:0] setting_group, // Active group minus one
	input wire logic signed [dcb_pkg::AW-1:0] angle, // I1 to U1 angle, 0.01 deg
	input wire logic [dcb_pkg::TSW-1:0] ts_ms, // Time stamp, ms
	input wire logic [1:0] rd_stage, // Record read stage
	input wire logic [3:0] rd_idx, // Record read, 0 newest
	output logic [dcb_pkg::NSTG-1:0] start_o, // Start status
	output logic [dcb_pkg::NSTG-1:0] trip_o, // Trip status
	output logic [dcb_pkg::NSTG-1:0] blocked_o, // Blocked status
	output logic [dcb_pkg::NSTG-1:0] disp_note, // Blocked display pulse
	output logic [dcb_pkg::NSTG-1:0][2:0] stage_behaviour_state, // Behaviour code
	output logic [dcb_pkg::NSTG-1:0][dcb_pkg::TW-1:0] exp_time, // Expected time
	output logic [dcb_pkg::NSTG-1:0][dcb_pkg::TW:0] remain, // Signed time to trip
	output logic [dcb_pkg::NSTG-1:0][dcb_pkg::IW-1:0] ratio, // Im/Iset, 0.01
	output logic signed [dcb_pkg::AW-1:0] angle_now, // Live angle
	output logic ev_valid, // Event pulse
	output logic [1:0] ev_stage, // Stage of event
	output logic [3:0] ev_code, // Signal*2 + off
	output logic [dcb_pkg::TSW-1:0] ev_time, // Event time stamp
	output logic [dcb_pkg::IW-1:0] ev_cur, // Current at event
	output logic [3:0] ev_fault, // Fault type at event
	output logic rec_valid, // Record slot filled
	output logic [dcb_pkg::TSW-1:0] rec_ts, // Record time
	output logic [3:0] rec_code, // Record event code
	output logic [3:0] rec_ft, // Record fault type
	output logic [dcb_pkg::IW-1:0] rec_pre, // Record pre-trigger current
	output logic [dcb_pkg::IW-1:0] rec_flt, // Record fault current
	output logic [dcb_pkg::IW-1:0] rec_avg, // Record pre-fault average
	output logic [dcb_pkg::TW:0] rec_rem, // Record remaining time
	output logic [2:0] rec_sg, // Record setting group
	output logic signed [dcb_pkg::AW-1:0] rec_ang // Record angle
);
	import dcb_pkg::*;

	// ----------------------------------------
	// Program cycle divider
	// ----------------------------------------
	logic [DIVW-1:0] div_q;
	logic tick_q;
	logic eval_q;

	// Tick samples the block, eval one clock later runs the stages
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			div_q <= '0;
			tick_q <= 1'b0;
			eval_q <= 1'b0;
		end
		else
		begin
			tick_q <= (div_q == DIVW'(CYCLE_CLKS - 1));
			div_q <= (div_q == DIVW'(CYCLE_CLKS - 1)) ? '0 : div_q + 1'b1;
			eval_q <= tick_q;
		end
	end

	// ----------------------------------------
	// Blocking input capture
	// ----------------------------------------
	logic [NSTG-1:0] blk_s1_q;
	logic [NSTG-1:0] blk_s2_q;
	logic [NSTG-1:0] blk_smp_q;

	// Held for the whole cycle so a mid-cycle change cannot split a decision
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			blk_s1_q <= '0;
			blk_s2_q <= '0;
			blk_smp_q <= '0;
		end
		else
		begin
			blk_s1_q <= block_in;
			blk_s2_q <= blk_s1_q;
			if (tick_q)
				blk_smp_q <= blk_s2_q;
		end
	end

	// ----------------------------------------
	// Stages
	// ----------------------------------------
	logic [NSTG-1:0][NEV-1:0] pend_w;
	logic [NSTG-1:0][NEV-1:0] clr_w;
	logic [NSTG-1:0][2:0] on_w;
	logic [NSTG-1:0][TW:0] rem_w;

	genvar g;
	for (g = 0; g < NSTG; g++)
	begin : g_stg
		dcb_state_e st_q;
		logic [TW-1:0] cnt_q;
		logic [TW-1:0] rcnt_q;
		logic start_q;
		logic trip_q;
		logic blk_q;
		logic note_q;
		logic [2:0] beh_q;
		logic [TW-1:0] exp_q;
		logic [TW:0] rem_q;
		logic [IW-1:0] ratio_q;
		logic [NSIG-1:0] prv_q;
		logic [NEV-1:0] pend_q;
		logic [NEV-1:0] set_v;
		logic [NSIG-1:0] cur;
		logic [TW-1:0] op_t;
		logic [TW-1:0] rs_t;
		logic [TW-1:0] cnt_n;
		logic [TW-1:0] rcnt_n;
		logic eblk;
		logic inr;
		logic off;

		// Cycle decisions use the sampled block and the mode
		assign off = (set_mode[g] == BEH_OFF);
		assign eblk = blk_smp_q[g] | (set_mode[g] == BEH_BLK) | (set_mode[g] == BEH_TBLK);
		assign inr = inrush_en[g] & (harm_ratio >= harm_limit[g]);
		assign op_t = delay_inv[g] ? op_inv[g] : op_def[g];
		assign rs_t = delay_inv[g] ? rs_inv[g] : rs_def[g];
		assign cnt_n = cnt_q + 1'b1;
		assign rcnt_n = rcnt_q + 1'b1;

		// Operate and release timing
		always_ff @(posedge clk)
		begin
			if (rst || off)
			begin
				st_q <= ST_IDLE;
				cnt_q <= TIME_RST;
				rcnt_q <= TIME_RST;
				start_q <= 1'b0;
				trip_q <= 1'b0;
			end
			else if (eval_q)
			begin
				unique case (st_q)
					ST_IDLE:
						if (pickup[g])
						begin
							if (eblk)
								st_q <= ST_BLK;
							else
							begin
								start_q <= 1'b1;
								cnt_q <= TIME_RST;
								st_q <= ST_RUN;
							end
						end
					ST_RUN:
						if (eblk || !pickup[g])
						begin
							cnt_q <= TIME_RST;
							rcnt_q <= TIME_RST;
							st_q <= ST_REL;
						end
						else if (cnt_n >= op_t && !inr)
						begin
							trip_q <= 1'b1;
							st_q <= ST_TRIP;
						end
						else
							cnt_q <= (cnt_n > op_t) ? op_t : cnt_n; // Inrush holds at the limit
					ST_TRIP:
						if (eblk || !pickup[g])
						begin
							rcnt_q <= TIME_RST;
							st_q <= ST_REL;
						end
					ST_REL:
						if (pickup[g] && !eblk)
							st_q <= trip_q ? ST_TRIP : ST_RUN;
						else if (rcnt_n >= rs_t)
						begin
							start_q <= 1'b0;
							trip_q <= 1'b0;
							st_q <= (eblk && pickup[g]) ? ST_BLK : ST_IDLE;
						end
						else
							rcnt_q <= rcnt_n;
					ST_BLK:
						if (!eblk)
							st_q <= ST_IDLE;
				endcase
			end
		end

		// Blocked status and display note
		always_ff @(posedge clk)
		begin
			if (rst || off)
			begin
				blk_q <= 1'b0;
				note_q <= 1'b0;
			end
			else
			begin
				note_q <= eval_q && eblk && pickup[g] && !blk_q && st_q != ST_REL;
				if (eval_q && !eblk)
					blk_q <= 1'b0;
				else if (eval_q && pickup[g] && st_q != ST_REL)
					blk_q <= 1'b1;
			end
		end

		// Live readings
		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				exp_q <= TIME_RST;
				rem_q <= '0;
				ratio_q <= '0;
				beh_q <= BEH_ON;
			end
			else
			begin
				exp_q <= op_t;
				rem_q <= (st_q == ST_RUN) ? ({1'b0, op_t} - {1'b0, cnt_q}) : '0;
				ratio_q <= (i_set[g] == '0) ? '1 :
					IW'((32'(i_max) * 32'(RATIO_SCALE)) / 32'(i_set[g]));
				if (off)
					beh_q <= BEH_OFF;
				else if (set_mode[g] == BEH_TEST || set_mode[g] == BEH_TBLK)
					beh_q <= (blk_q || eblk) ? BEH_TBLK : BEH_TEST;
				else
					beh_q <= (blk_q || eblk) ? BEH_BLK : BEH_ON;
			end
		end

		// Status change detection; on/off filter only for start, trip, block
		assign cur = {volt_mem[g], live_ang[g], no_volt[g], blk_q, trip_q, start_q};
		always_comb
		begin
			set_v = '0;
			for (int s = 0; s < NSIG; s++)
			begin
				set_v[2*s] = cur[s] & ~prv_q[s] & (s >= SIG_NFILT || ev_sel[g] != EVSEL_OFF);
				set_v[2*s+1] = ~cur[s] & prv_q[s] & (s >= SIG_NFILT || ev_sel[g] != EVSEL_ON);
			end
		end

		// Pending events; a new edge wins over the grant clear
		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				prv_q <= '0;
				pend_q <= '0;
			end
			else
			begin
				prv_q <= cur;
				pend_q <= (pend_q & ~clr_w[g]) | set_v;
			end
		end

		assign pend_w[g] = pend_q;
		assign on_w[g] = cur[2:0] & ~prv_q[2:0];
		assign rem_w[g] = rem_q;
		assign start_o[g] = start_q;
		assign trip_o[g] = trip_q;
		assign blocked_o[g] = blk_q;
		assign disp_note[g] = note_q;
		assign stage_behaviour_state[g] = beh_q;
		assign exp_time[g] = exp_q;
		assign remain[g] = rem_q;
		assign ratio[g] = ratio_q;
	end

	// ----------------------------------------
	// Event arbiter
	// ----------------------------------------
	logic gnt;
	logic [1:0] gnt_stg;
	logic [3:0] gnt_code;

	// Fixed priority, lowest stage and code first; one event per clock
	always_comb
	begin
		gnt = 1'b0;
		gnt_stg = '0;
		gnt_code = '0;
		clr_w = '0;
		for (int s = 0; s < NSTG; s++)
			for (int c = 0; c < NEV; c++)
				if (!gnt && pend_w[s][c])
				begin
					gnt = 1'b1;
					gnt_stg = 2'(s);
					gnt_code = 4'(c);
					clr_w[s][c] = 1'b1;
				end
	end

	// Event output with stamp and process values
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ev_valid <= 1'b0;
			ev_stage <= '0;
			ev_code <= '0;
			ev_time <= '0;
			ev_cur <= '0;
			ev_fault <= '0;
			angle_now <= '0;
		end
		else
		begin
			ev_valid <= gnt;
			ev_stage <= gnt_stg;
			ev_code <= gnt_code;
			ev_time <= ts_ms;
			ev_cur <= i_max;
			ev_fault <= fault_type;
			angle_now <= angle;
		end
	end

	// ----------------------------------------
	// Record store
	// ----------------------------------------
	logic [TSW-1:0] r_ts [NSTG][NREC];
	logic [3:0] r_code [NSTG][NREC];
	logic [3:0] r_ft [NSTG][NREC];
	logic [IW-1:0] r_pre [NSTG][NREC];
	logic [IW-1:0] r_flt [NSTG][NREC];
	logic [IW-1:0] r_avg [NSTG][NREC];
	logic [TW:0] r_rem [NSTG][NREC];
	logic [2:0] r_sg [NSTG][NREC];
	logic signed [AW-1:0] r_ang [NSTG][NREC];
	logic [3:0] wp_q [NSTG];
	logic [3:0] fill_q [NSTG];

	// One record per edge cycle; simultaneous edges keep trip over start over block
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int s = 0; s < NSTG; s++)
			begin
				wp_q[s] <= PTR_RST;
				fill_q[s] <= PTR_RST;
			end
		end
		else
		begin
			for (int s = 0; s < NSTG; s++)
				if (on_w[s] != 3'h0)
				begin
					r_ts[s][wp_q[s]] <= ts_ms;
					r_code[s][wp_q[s]] <= on_w[s][1] ? EV_TRIP_ON : on_w[s][0] ? EV_START_ON : EV_BLOCK_ON;
					r_ft[s][wp_q[s]] <= fault_type;
					r_pre[s][wp_q[s]] <= i_pre;
					r_flt[s][wp_q[s]] <= i_max;
					r_avg[s][wp_q[s]] <= i_avg;
					r_rem[s][wp_q[s]] <= rem_w[s];
					r_sg[s][wp_q[s]] <= setting_group;
					r_ang[s][wp_q[s]] <= angle;
					wp_q[s] <= (wp_q[s] == 4'(NREC - 1)) ? PTR_RST : wp_q[s] + 1'b1;
					if (fill_q[s] != 4'(NREC))
						fill_q[s] <= fill_q[s] + 1'b1;
				end
		end
	end

	// Newest-first read, slot counted back from the write pointer
	logic [4:0] slot;
	always_comb
	begin
		slot = {1'b0, wp_q[rd_stage]} + 5'(NREC) - 5'h1 - {1'b0, rd_idx};
		if (slot >= 5'(NREC))
			slot = slot - 5'(NREC);
	end

	// Registered read data, one clock after the address
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rec_valid <= 1'b0;
			rec_ts <= '0;
			rec_code <= '0;
			rec_ft <= '0;
			rec_pre <= '0;
			rec_flt <= '0;
			rec_avg <= '0;
			rec_rem <= '0;
			rec_sg <= '0;
			rec_ang <= '0;
		end
		else
		begin
			rec_valid <= (rd_idx < fill_q[rd_stage]);
			rec_ts <= r_ts[rd_stage][slot[3:0]];
			rec_code <= r_code[rd_stage][slot[3:0]];
			rec_ft <= r_ft[rd_stage][slot[3:0]];
			rec_pre <= r_pre[rd_stage][slot[3:0]];
			rec_flt <= r_flt[rd_stage][slot[3:0]];
			rec_avg <= r_avg[rd_stage][slot[3:0]];
			rec_rem <= r_rem[rd_stage][slot[3:0]];
			rec_sg <= r_sg[rd_stage][slot[3:0]];
			rec_ang <= r_ang[rd_stage][slot[3:0]];
		end
	end
endmodule : dcb_dir_overcurrent_event_block
`default_nettype wire

/* bench/dcb_checker.sv */
// Port assertions for the directional overcurrent event block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module dcb_checker
	import dcb_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic [dcb_pkg::NSTG-1:0] start_o, // Start
	input wire logic [dcb_pkg::NSTG-1:0] trip_o, // Trip
	input wire logic [dcb_pkg::NSTG-1:0] blocked_o, // Blocked
	input wire logic [dcb_pkg::NSTG-1:0] disp_note, // Note pulse
	input wire logic [dcb_pkg::NSTG-1:0][2:0] stage_behaviour_state, // Behaviour
	input wire logic [dcb_pkg::NSTG-1:0][dcb_pkg::TW:0] remain, // Time left
	input wire logic [dcb_pkg::NSTG-1:0][2:0] set_mode, // Mode request
	input wire logic [dcb_pkg::NSTG-1:0][1:0] ev_sel, // Edge select
	input wire logic ev_valid, // Event pulse
	input wire logic [1:0] ev_stage, // Event stage
	input wire logic [3:0] ev_code, // Event code
	input wire logic [dcb_pkg::TSW-1:0] ev_time, // Event time
	input wire logic [dcb_pkg::TSW-1:0] ts_ms, // Time stamp
	input wire logic signed [dcb_pkg::AW-1:0] angle, // Angle in
	input wire logic signed [dcb_pkg::AW-1:0] angle_now, // Angle out
	input wire logic [3:0] rd_idx, // Record index
	input wire logic rec_valid // Record filled
);
	// ----
	// Assertions
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_start_unblocked: assert property ((start_o & ~$past(start_o) & blocked_o) == '0)
		else $error("start rose while blocked");
	chk_trip_has_start: assert property ((trip_o & ~start_o) == '0)
		else $error("trip without start");
	chk_mode_off: assert property ((set_mode[3] == BEH_OFF) [*3] |-> (start_o[3] | trip_o[3] | blocked_o[3]) == 1'b0)
		else $error("off stage shows status");
	chk_beh_range: assert property (stage_behaviour_state[3] inside {[BEH_ON:BEH_OFF]})
		else $error("behaviour code out of range");
	chk_note_raise: assert property ($rose(blocked_o[1]) |-> ##[0:1] disp_note[1])
		else $error("no display note on block");
	chk_note_pulse: assert property (disp_note[1] |=> !disp_note[1])
		else $error("display note too long");
	chk_start_event: assert property ($rose(start_o[0]) && ev_sel[0] != EVSEL_OFF
		|-> ##[1:3] (ev_valid && ev_stage == 2'h0 && ev_code == EV_START_ON))
		else $error("start event missing");
	chk_off_dropped: assert property (ev_valid && ev_sel[ev_stage] == EVSEL_ON && ev_code < 4'h6 |-> !ev_code[0])
		else $error("off event not filtered");
	chk_ev_code: assert property (ev_valid |-> ev_code < 4'hc)
		else $error("event code out of range");
	chk_ev_time: assert property (ev_valid |-> ev_time == $past(ts_ms))
		else $error("event time stamp wrong");
	chk_angle_live: assert property (!$past(rst) |-> angle_now == $past(angle))
		else $error("live angle wrong");
	chk_rec_empty: assert property ($past(rd_idx) >= 4'hc |-> !rec_valid)
		else $error("record beyond store valid");
	chk_remain_idle: assert property ((!start_o[2]) [*3] |-> remain[2] == '0)
		else $error("remaining time while idle");
	// Main scenarios seen
	cov_trip: cover property ($rose(trip_o[0]));
	cov_block: cover property ($rose(blocked_o[1]));
	cov_blk_ev: cover property (ev_valid && ev_code == EV_BLOCK_ON);
	cov_off: cover property (stage_behaviour_state[3] == BEH_OFF);
endmodule : dcb_checker
bind dcb_dir_overcurrent_event_block dcb_checker u_dcb_checker (.clk, .rst, .start_o, .trip_o, .blocked_o,
	.disp_note, .stage_behaviour_state, .remain, .set_mode, .ev_sel, .ev_valid, .ev_stage, .ev_code,
	.ev_time, .ts_ms, .angle, .angle_now, .rd_idx, .rec_valid);
`default_nettype wire

/* bench/dcb_evt_sink.sv */
// Event buffer model: counts events per stage and code.
// Assumes events arrive as one-cycle pulses on the block clock.
`timescale 1ns/10ps
`default_nettype none
module dcb_evt_sink (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic ev_valid, // Event pulse
	input wire logic [1:0] ev_stage, // Stage of event
	input wire logic [3:0] ev_code // Event code
);
	logic [7:0] cnt [4][12];
	// Buffer cleared on reset; codes past the table ignored
	always_ff @(posedge clk)
	begin
		if (rst)
			cnt <= '{default: '0};
		else if (ev_valid && ev_code < 4'hc)
			cnt[ev_stage][ev_code] <= cnt[ev_stage][ev_code] + 8'h01;
	end
endmodule : dcb_evt_sink
`default_nettype wire

/* bench/test_dcb_dir_overcurrent_event_block.sv */
// Self-checking bench for the directional overcurrent event block.
// Assumes a short program cycle of 8 clocks through CYCLE_CLKS.
`timescale 1ns/10ps
`default_nettype none
module test_dcb_dir_overcurrent_event_block;
	import dcb_pkg::*;
	logic clk, rst;
	logic [NSTG-1:0] pickup, block_in, inrush_en, delay_inv, no_volt, live_ang, volt_mem;
	logic [HW-1:0] harm_ratio;
	logic [NSTG-1:0][HW-1:0] harm_limit;
	logic [NSTG-1:0][TW-1:0] op_def, op_inv, rs_def, rs_inv;
	logic [NSTG-1:0][2:0] set_mode, stage_behaviour_state;
	logic [NSTG-1:0][1:0] ev_sel;
	logic [IW-1:0] i_max, i_pre, i_avg, ev_cur, rec_pre, rec_flt, rec_avg;
	logic [NSTG-1:0][IW-1:0] i_set, ratio;
	logic [3:0] fault_type, rd_idx, ev_code, ev_fault, rec_code, rec_ft;
	logic [2:0] setting_group, rec_sg;
	logic signed [AW-1:0] angle, angle_now, rec_ang;
	logic [TSW-1:0] ts_ms, ev_time, rec_ts;
	logic [1:0] rd_stage, ev_stage;
	logic [NSTG-1:0] start_o, trip_o, blocked_o, disp_note;
	logic [NSTG-1:0][TW-1:0] exp_time;
	logic [NSTG-1:0][TW:0] remain;
	logic [TW:0] rec_rem;
	logic ev_valid, rec_valid;
	int bad_count, compares, k;
	dcb_dir_overcurrent_event_block #(.CYCLE_CLKS(8)) u_dcb_dir_overcurrent_event_block (.clk, .rst,
		.pickup, .block_in, .inrush_en, .harm_ratio, .harm_limit, .delay_inv, .op_def, .op_inv, .rs_def,
		.rs_inv, .set_mode, .ev_sel, .no_volt, .live_ang, .volt_mem, .i_max, .i_set, .i_pre, .i_avg,
		.fault_type, .setting_group, .angle, .ts_ms, .rd_stage, .rd_idx, .start_o, .trip_o, .blocked_o,
		.disp_note, .stage_behaviour_state, .exp_time, .remain, .ratio, .angle_now, .ev_valid, .ev_stage,
		.ev_code, .ev_time, .ev_cur, .ev_fault, .rec_valid, .rec_ts, .rec_code, .rec_ft, .rec_pre, .rec_flt,
		.rec_avg, .rec_rem, .rec_sg, .rec_ang);
	dcb_evt_sink u_dcb_evt_sink (.clk, .rst, .ev_valid, .ev_stage, .ev_code);
	// ----
	// Helpers
	// ----
	task test_done;
		if (bad_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	task chk(input logic [47:0] seen, input logic [47:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Drive points sit on the edge, check points 1 ns later
	task tk(input int n);
		repeat (n) @(posedge clk);
	endtask : tk
	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	// Bounded wait on start (0), trip (1) or blocked (2)
	task wfor(input int kd, input int s, input logic v);
		logic b;
		for (int i = 0; i < 200; i++)
		begin
			wt(1);
			b = (kd == 0) ? start_o[s] : (kd == 1) ? trip_o[s] : blocked_o[s];
			if (b === v)
				return;
		end
		chk(b, v);
		test_done();
	endtask : wfor
	task rd(input logic [1:0] s, input logic [3:0] i);
		tk(1);
		rd_stage <= s;
		rd_idx <= i;
		wt(2);
	endtask : rd
	// ----
	// Scenarios
	// ----
	task sc_run;
		tk(1);
		pickup[0] <= 1'b1;
		wfor(0, 0, 1'b1);
		wt(8);
		chk(trip_o[0], 1'b0);
		chk(|remain[0], 1'b1);
		wfor(1, 0, 1'b1);
		tk(1);
		pickup[0] <= 1'b0;
		wfor(0, 0, 1'b0);
		chk(trip_o[0], 1'b0);
		wt(4);
		chk(ev_cur, 16'h00c8);
		chk(ev_fault, 4'h9);
		for (k = 0; k < 4; k++)
			chk(u_dcb_evt_sink.cnt[0][k], 8'h01);
		rd(2'h0, 4'h0);
		chk(rec_code, EV_TRIP_ON);
		chk(rec_sg, 3'h5);
		chk(rec_ft, 4'h9);
		chk(rec_flt, 16'h00c8);
		chk(rec_pre, 16'h0011);
		chk(rec_avg, 16'h0022);
		rd(2'h0, 4'h1);
		chk(rec_code, EV_START_ON);
		rd(2'h0, 4'h2);
		chk(rec_valid, 1'b0);
	endtask : sc_run
	task sc_blk_pick;
		tk(1);
		block_in[1] <= 1'b1;
		tk(24);
		pickup[1] <= 1'b1;
		wfor(2, 1, 1'b1);
		wt(16);
		chk(start_o[1], 1'b0);
		rd(2'h1, 4'h0);
		chk(rec_code, EV_BLOCK_ON);
		tk(1);
		block_in[1] <= 1'b0;
		pickup[1] <= 1'b0;
		wfor(2, 1, 1'b0);
		wt(4);
		chk(u_dcb_evt_sink.cnt[1][4], 8'h01);
		chk(u_dcb_evt_sink.cnt[1][5], 8'h01);
		chk(u_dcb_evt_sink.cnt[1][0], 8'h00);
	endtask : sc_blk_pick
	task sc_blk_late;
		tk(1);
		pickup[2] <= 1'b1;
		wfor(0, 2, 1'b1);
		tk(1);
		block_in[2] <= 1'b1; // well ahead of the operate delay
		wfor(2, 2, 1'b1);
		wfor(0, 2, 1'b0);
		chk(trip_o[2], 1'b0);
		tk(1);
		block_in[2] <= 1'b0;
		pickup[2] <= 1'b0;
		wfor(2, 2, 1'b0);
		// Each flag pulsed alone so its two events stand apart
		for (k = 0; k < 3; k++)
		begin
			tk(1);
			{volt_mem[2], live_ang[2], no_volt[2]} <= 3'h1 << k;
			tk(4);
			{volt_mem[2], live_ang[2], no_volt[2]} <= 3'h0;
			tk(4);
		end
		wt(4);
		for (k = 6; k < 12; k++)
			chk(u_dcb_evt_sink.cnt[2][k], 8'h01);
	endtask : sc_blk_late
	task sc_inrush;
		tk(1);
		inrush_en[0] <= 1'b1;
		harm_ratio <= 13'h0100;
		pickup[0] <= 1'b1;
		wfor(0, 0, 1'b1);
		wt(64);
		chk(trip_o[0], 1'b0);
		tk(1);
		harm_ratio <= 13'h0008;
		wfor(1, 0, 1'b1);
		tk(1);
		pickup[0] <= 1'b0;
		inrush_en[0] <= 1'b0;
		wfor(0, 0, 1'b0);
	endtask : sc_inrush
	task sc_modes;
		chk(ratio[3], 16'h00c8);
		chk(exp_time[2], 20'h00014);
		// Stage 2 is idle from here on, so its delay type can move to inverse
		tk(1);
		delay_inv[2] <= 1'b1;
		op_inv[2] <= 20'h00021;
		wt(2);
		chk(exp_time[2], 20'h00021);
		for (k = 1; k < 6; k++)
		begin
			tk(1);
			set_mode[3] <= k[2:0];
			wt(4);
			chk(stage_behaviour_state[3], k[2:0]);
		end
		tk(1);
		pickup[3] <= 1'b1;
		wt(40);
		chk(start_o[3], 1'b0);
		tk(1);
		pickup[3] <= 1'b0;
		set_mode[3] <= BEH_ON;
		wt(4);
	endtask : sc_modes
	task sc_ring;
		for (k = 0; k < 13; k++)
		begin
			tk(1);
			ts_ms <= 48'(k);
			angle <= 17'(k);
			pickup[3] <= 1'b1;
			wfor(0, 3, 1'b1);
			tk(1);
			pickup[3] <= 1'b0;
			wfor(0, 3, 1'b0);
		end
		wt(4);
		chk(u_dcb_evt_sink.cnt[3][0], 8'h0d);
		chk(u_dcb_evt_sink.cnt[3][1], 8'h00);
		rd(2'h3, 4'h0);
		chk(rec_ts, 48'h00000000000c);
		chk(rec_ang, 17'h0000c);
		rd(2'h3, 4'hb);
		chk(rec_ts, 48'h000000000001);
		rd(2'h3, 4'hc);
		chk(rec_valid, 1'b0);
	endtask : sc_ring
	// ----
	// Clock and sequence
	// ----
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial
	begin
		bad_count = 0;
		compares = 0;
		rst = 1'b1;
		{pickup, block_in, inrush_en, delay_inv, no_volt, live_ang, volt_mem} = '0;
		harm_ratio = 13'h0000;
		harm_limit = {4{13'h0010}};
		op_def = {20'h000c8, 20'h00014, 20'h00003, 20'h00003};
		op_inv = '0;
		rs_def = {4{20'h00001}};
		rs_inv = '0;
		set_mode = {4{BEH_ON}};
		ev_sel = {EVSEL_ON, EVSEL_BOTH, EVSEL_BOTH, EVSEL_BOTH};
		i_max = 16'h00c8;
		i_set = {4{16'h0064}};
		i_pre = 16'h0011;
		i_avg = 16'h0022;
		fault_type = 4'h9;
		setting_group = 3'h5;
		angle = 17'h00000;
		ts_ms = 48'h000000000000;
		rd_stage = 2'h0;
		rd_idx = 4'h0;
		tk(20);
		rst <= 1'b0;
		wt(1);
		chk(stage_behaviour_state[0], BEH_ON);
		chk(rec_valid, 1'b0);
		sc_run();
		sc_blk_pick();
		sc_blk_late();
		sc_inrush();
		sc_modes();
		sc_ring();
		// Second reset empties the store; index 0 would read a filled slot without it
		tk(1);
		rst <= 1'b1;
		rd_idx <= 4'h0;
		tk(2);
		rst <= 1'b0;
		wt(2);
		chk(rec_valid, 1'b0);
		test_done();
	end
endmodule : test_dcb_dir_overcurrent_event_block
`default_nettype wire
